/* File: verilog/temp_spi_host.sv */
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
module temp_spi_host
  import temp_spi_host_pkg::*;
#(
  parameter int SCLK_HALF = SCLK_HALF_CYC,
  parameter int GUARD_CYC = GUARD_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso,
  input wire logic i_alarm,
  input wire logic i_critical_alarm_out
);
  localparam int GW = $clog2(GUARD_CYC + 1);
  localparam logic [GW-1:0] GUARD_LOAD = GW'(GUARD_CYC - 1);

  spi_state_e st_q;
  xfer_cfg_s cfg_q;
  logic [15:0] txd_q;
  logic [15:0] rxd_q;
  logic [23:0] tx_sh_q;
  logic [15:0] rx_sh_q;
  logic [5:0] bit_cnt_q;
  logic [5:0] total_q;
  logic sif_q;
  logic rd_q;
  logic wide_q;
  logic cs_q;
  logic sclk_q;
  logic mosi_q;
  logic done_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [GW-1:0] guard_cnt_q;
  logic tick;
  logic run;
  logic miso_s;
  logic alarm_s;
  logic crit_s;
  logic wb_hit;
  logic wb_wr;
  logic start_req;
  logic sifrst_req;
  logic done_clr;
  logic frame_end;
  logic [2:0] pins_s;
  logic alarm_act;
  logic crit_act;
  logic [31:0] stat_word;
  logic [31:0] ctrl_word;

  sync2 #(
    .W(3)
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_miso, i_alarm, i_critical_alarm_out}),
    .o_sync(pins_s)
  );

  assign miso_s = pins_s[2];
  assign alarm_s = pins_s[1];
  assign crit_s = pins_s[0];

  // divider runs only from frame start through the gap after it; the guard wait counts raw cycles
  assign run = (st_q != ST_IDLE) && (st_q != ST_GUARD);

  sclk_tick #(
    .HALF(SCLK_HALF)
  ) u_tick (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_run(run),
    .o_tick(tick)
  );

  // wishbone classic slave, one wait state, ack for one cycle
  assign wb_hit = i_wb_cyc && i_wb_stb && !ack_q;
  assign wb_wr = wb_hit && i_wb_we;
  assign start_req = wb_wr && (i_wb_adr == CTRL_OFS) && i_wb_sel[0] && i_wb_dat[CTRL_START_BIT] && (st_q == ST_IDLE);
  assign sifrst_req = wb_wr && (i_wb_adr == CTRL_OFS) && i_wb_sel[0] && i_wb_dat[CTRL_SIFRST_BIT]
    && (st_q == ST_IDLE);
  assign done_clr = wb_wr && (i_wb_adr == STAT_OFS) && i_wb_sel[0] && i_wb_dat[STAT_DONE_BIT];
  assign frame_end = (st_q == ST_TRAIL) && tick;

  // pins are open-drain levels; polarity says which level means active
  assign alarm_act = cfg_q.pol_high ? alarm_s : !alarm_s;
  assign crit_act = cfg_q.pol_high ? crit_s : !crit_s;

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[STAT_BUSY_BIT] = (st_q != ST_IDLE);
    stat_word[STAT_DONE_BIT] = done_q;
    stat_word[STAT_GUARD_BIT] = (st_q == ST_GUARD);
    stat_word[STAT_ALARM_BIT] = alarm_act;
    stat_word[STAT_CRIT_BIT] = crit_act;
    stat_word[STAT_ALARM_RAW_BIT] = alarm_s;
    stat_word[STAT_CRIT_RAW_BIT] = crit_s;
  end

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[CTRL_READ_BIT] = cfg_q.read;
    ctrl_word[CTRL_ADDR_LSB +: 3] = cfg_q.addr;
    ctrl_word[CTRL_WIDE_BIT] = cfg_q.wide;
    ctrl_word[CTRL_3W_BIT] = cfg_q.three_wire;
    ctrl_word[CTRL_POL_BIT] = cfg_q.pol_high;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_hit;
    end
  end

  // unmapped offsets read as zero and are still acknowledged
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      rdat_q <= 32'h0000_0000;
    end else if (wb_hit && !i_wb_we) begin
      if (i_wb_adr == CTRL_OFS) begin
        rdat_q <= ctrl_word;
      end else if (i_wb_adr == TXD_OFS) begin
        rdat_q <= {16'h0000, txd_q};
      end else if (i_wb_adr == RXD_OFS) begin
        rdat_q <= {16'h0000, rxd_q};
      end else if (i_wb_adr == STAT_OFS) begin
        rdat_q <= stat_word;
      end else begin
        rdat_q <= 32'h0000_0000;
      end
    end
  end

  // configuration may change mid-frame; read, addr and wide are copied at start, but three_wire acts on o_cs_n at once
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cfg_q <= CFG_RESET;
    end else if (wb_wr && (i_wb_adr == CTRL_OFS)) begin
      if (i_wb_sel[0]) begin
        cfg_q.read <= i_wb_dat[CTRL_READ_BIT];
        cfg_q.addr <= i_wb_dat[CTRL_ADDR_LSB +: 3];
        cfg_q.wide <= i_wb_dat[CTRL_WIDE_BIT];
        cfg_q.three_wire <= i_wb_dat[CTRL_3W_BIT];
      end
      if (i_wb_sel[1]) begin
        cfg_q.pol_high <= i_wb_dat[CTRL_POL_BIT];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      txd_q <= TXD_RESET;
    end else if (wb_wr && (i_wb_adr == TXD_OFS)) begin
      if (i_wb_sel[0]) begin
        txd_q[7:0] <= i_wb_dat[7:0];
      end
      if (i_wb_sel[1]) begin
        txd_q[15:8] <= i_wb_dat[15:8];
      end
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      done_q <= 1'b0;
    end else if (frame_end) begin
      done_q <= 1'b1;
    end else if (done_clr) begin
      done_q <= 1'b0;
    end
  end

  // frame sequencer
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (start_req || sifrst_req) begin
            st_q <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          if (tick) begin
            st_q <= ST_RISE;
          end
        end
        ST_FALL: begin
          if (tick) begin
            st_q <= ST_RISE;
          end
        end
        ST_RISE: begin
          if (tick) begin
            st_q <= (bit_cnt_q + 6'h01 == total_q) ? ST_TRAIL : ST_FALL;
          end
        end
        ST_TRAIL: begin
          if (tick) begin
            st_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (tick) begin
            st_q <= sif_q ? ST_GUARD : ST_IDLE;
          end
        end
        ST_GUARD: begin
          if (guard_cnt_q == '0) begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // frame kind captured at start
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      sif_q <= 1'b0;
      rd_q <= 1'b0;
      wide_q <= 1'b0;
      total_q <= BITS_NARROW;
    end else if (st_q == ST_IDLE && sifrst_req) begin
      sif_q <= 1'b1;
      rd_q <= 1'b0;
      wide_q <= 1'b0;
      total_q <= SIF_RESET_ONES;
    end else if (st_q == ST_IDLE && start_req) begin
      sif_q <= 1'b0;
      rd_q <= i_wb_dat[CTRL_READ_BIT];
      wide_q <= i_wb_dat[CTRL_WIDE_BIT];
      total_q <= i_wb_dat[CTRL_WIDE_BIT] ? BITS_WIDE : BITS_NARROW;
    end
  end

  // command byte then data, both msb first; read frames send zeros after the command
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      tx_sh_q <= 24'h00_0000;
    end else if (st_q == ST_IDLE && sifrst_req) begin
      tx_sh_q <= 24'hff_ffff;
    end else if (st_q == ST_IDLE && start_req) begin
      if (i_wb_dat[CTRL_READ_BIT]) begin
        tx_sh_q <= {make_cmd(1'b1, i_wb_dat[CTRL_ADDR_LSB +: 3]), 16'h0000};
      end else if (i_wb_dat[CTRL_WIDE_BIT]) begin
        tx_sh_q <= {make_cmd(1'b0, i_wb_dat[CTRL_ADDR_LSB +: 3]), txd_q};
      end else begin
        tx_sh_q <= {make_cmd(1'b0, i_wb_dat[CTRL_ADDR_LSB +: 3]), txd_q[7:0], 8'h00};
      end
    end else if (st_q == ST_RISE && tick) begin
      tx_sh_q <= {tx_sh_q[22:0], 1'b0};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      bit_cnt_q <= 6'h00;
    end else if (st_q == ST_IDLE) begin
      bit_cnt_q <= 6'h00;
    end else if (st_q == ST_RISE && tick) begin
      bit_cnt_q <= bit_cnt_q + 6'h01;
    end
  end

  // chip select: a reset run is framed too so a frame-synced device sees it
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cs_q <= 1'b1;
    end else if (st_q == ST_IDLE && (start_req || sifrst_req)) begin
      cs_q <= 1'b0;
    end else if (frame_end) begin
      cs_q <= 1'b1;
    end
  end

  // in three-wire use the pin stays low and framing rests on counting
  assign o_cs_n = cfg_q.three_wire ? 1'b0 : cs_q;

  // clock idles high; host drives on the fall, samples on the rise
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      sclk_q <= 1'b1;
    end else if ((st_q == ST_LEAD || st_q == ST_FALL) && tick) begin
      sclk_q <= 1'b0;
    end else if (st_q == ST_RISE && tick) begin
      sclk_q <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      mosi_q <= 1'b0;
    end else if ((st_q == ST_LEAD || st_q == ST_FALL) && tick) begin
      mosi_q <= sif_q ? 1'b1 : tx_sh_q[23];
    end
  end

  // miso changed half a period earlier, so the two-flop delay is harmless
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      rx_sh_q <= 16'h0000;
    end else if (st_q == ST_RISE && tick) begin
      rx_sh_q <= {rx_sh_q[14:0], miso_s};
    end
  end

  // a narrow read keeps the last eight bits in the low byte
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      rxd_q <= 16'h0000;
    end else if (frame_end && rd_q && !sif_q) begin
      rxd_q <= wide_q ? rx_sh_q : {8'h00, rx_sh_q[7:0]};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      guard_cnt_q <= '0;
    end else if (st_q == ST_GAP && tick) begin
      guard_cnt_q <= GUARD_LOAD;
    end else if (st_q == ST_GUARD && guard_cnt_q != '0) begin
      guard_cnt_q <= guard_cnt_q - 1'b1;
    end
  end

  assign o_sclk = sclk_q;
  assign o_mosi = mosi_q;
  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_mosi_on_fall;
    $changed(o_mosi) |-> $fell(o_sclk);
  endproperty
  a_mosi_on_fall: assert property (p_mosi_on_fall) else $error("mosi moved without a falling clock");

  property p_sample_on_rise;
    $changed(rx_sh_q) |-> $rose(o_sclk);
  endproperty
  a_sample_on_rise: assert property (p_sample_on_rise) else $error("miso sampled off a rising clock");

  property p_cs_opens_frame;
    $fell(cs_q) |-> o_sclk && (bit_cnt_q == 6'h00) ##1 (st_q == ST_LEAD);
  endproperty
  a_cs_opens_frame: assert property (p_cs_opens_frame) else $error("frame not opened by chip select");

  property p_cmd_reserved_zero;
    ($rose(o_sclk) && !sif_q && (bit_cnt_q == 6'h01 || bit_cnt_q == 6'h06 || bit_cnt_q == 6'h07
      || bit_cnt_q == 6'h08)) |-> !o_mosi;
  endproperty
  a_cmd_reserved_zero: assert property (p_cmd_reserved_zero) else $error("reserved command bit sent as one");

  property p_cmd_direction;
    ($rose(o_sclk) && !sif_q && bit_cnt_q == 6'h02) |-> (o_mosi == rd_q);
  endproperty
  a_cmd_direction: assert property (p_cmd_direction) else $error("direction bit does not match request");

  property p_frame_length;
    $rose(cs_q) |-> (bit_cnt_q == total_q) && (sif_q ? (total_q == SIF_RESET_ONES)
      : (total_q == (wide_q ? BITS_WIDE : BITS_NARROW)));
  endproperty
  a_frame_length: assert property (p_frame_length) else $error("frame closed with wrong clock count");

  property p_one_register;
    $rose(cs_q) |-> ##1 (st_q == ST_GAP) && cs_q;
  endproperty
  a_one_register: assert property (p_one_register) else $error("frame did not end after one register");

  property p_reset_ones;
    (sif_q && $rose(o_sclk)) |-> o_mosi;
  endproperty
  a_reset_ones: assert property (p_reset_ones) else $error("zero sent during interface reset run");

  property p_idle_high;
    (st_q == ST_IDLE || st_q == ST_GUARD || st_q == ST_GAP) |-> o_sclk;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("serial clock not high between frames");

  property p_guard_hold;
    (st_q == ST_GUARD && guard_cnt_q != '0) |=> (st_q == ST_GUARD) && cs_q;
  endproperty
  a_guard_hold: assert property (p_guard_hold) else $error("transfer started inside reset guard");

  property p_read_capture;
    (frame_end && rd_q && !sif_q && wide_q) |=> (rxd_q == $past(rx_sh_q));
  endproperty
  a_read_capture: assert property (p_read_capture) else $error("read data not captured at frame end");
endmodule

/* File: verilog/temp_spi_host_pkg.sv */
// Overview of operation
// - device shifts out on falling clock, samples on rising; host does the same
// - host opens each transfer by lowering chip select, then sends command byte (in three-wire mode o_cs_n stays low throughout)
// - host sends zero in command bit 7 and bits 2 to 0
// - command bit 6 selects direction: one reads, zero writes
// - write data of 8 or 16 bits follows the command, loaded on rising edges
// - host raises chip select after each write; one register per transfer (in three-wire mode o_cs_n stays low)
// - read: host gives 8 or 16 clocks after command, device drives from first fall
// - host leaves serial clock idling high between transfers
// - thirty-two or more ones on serial input reset the device interface
// - host waits at least 500 us after an interface reset
package temp_spi_host_pkg;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] TXD_OFS = 4'h4;
  localparam logic [3:0] RXD_OFS = 4'h8;
  localparam logic [3:0] STAT_OFS = 4'hc;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_READ_BIT = 1;
  localparam int CTRL_ADDR_LSB = 2;
  localparam int CTRL_WIDE_BIT = 5;
  localparam int CTRL_SIFRST_BIT = 6;
  localparam int CTRL_3W_BIT = 7;
  localparam int CTRL_POL_BIT = 8;

  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_GUARD_BIT = 2;
  localparam int STAT_ALARM_BIT = 3;
  localparam int STAT_CRIT_BIT = 4;
  localparam int STAT_ALARM_RAW_BIT = 5;
  localparam int STAT_CRIT_RAW_BIT = 6;

  localparam logic [5:0] BITS_NARROW = 6'h10;
  localparam logic [5:0] BITS_WIDE = 6'h18;
  localparam logic [5:0] SIF_RESET_ONES = 6'h20;

  localparam int GUARD_TIME_US = 500;
  localparam int REF_CLK_MHZ = 250;
  localparam int GUARD_CYCLES = GUARD_TIME_US * REF_CLK_MHZ;
  localparam int SCLK_HALF_CYC = 4;

  localparam logic [15:0] TXD_RESET = 16'h0000;

  typedef struct packed {
    logic pol_high;
    logic three_wire;
    logic wide;
    logic [2:0] addr;
    logic read;
  } xfer_cfg_s;

  localparam xfer_cfg_s CFG_RESET = '{pol_high: 1'b0, three_wire: 1'b0, wide: 1'b0, addr: 3'h0, read: 1'b0};

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LEAD = 3'b001,
    ST_FALL = 3'b010,
    ST_RISE = 3'b011,
    ST_TRAIL = 3'b100,
    ST_GAP = 3'b101,
    ST_GUARD = 3'b110
  } spi_state_e;

  function automatic logic [7:0] make_cmd(input logic read, input logic [2:0] addr);
    make_cmd = {1'b0, read, addr, 3'b000};
  endfunction
endpackage

/* File: verilog/sync2.sv */
module sync2
  import temp_spi_host_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule

/* File: verilog/sclk_tick.sv */
module sclk_tick
  import temp_spi_host_pkg::*;
#(
  parameter int HALF = SCLK_HALF_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_run,
  output logic o_tick
);
  localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);
  logic [CW-1:0] cnt_q;

  // restarts on every frame so the first half period is full length
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || !i_run) begin
      cnt_q <= '0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign o_tick = i_run && (cnt_q == LAST);
endmodule

/* File: tb/sensor_dev_model.sv */
module sensor_dev_model #(
  parameter logic [7:0] ID_VAL = 8'h5a, // arbitrary value
  parameter logic [15:0] STAT_RST = 16'h0000,
  parameter logic [15:0] CFG_RST = 16'h0000,
  parameter logic [15:0] TEMP_RST = 16'h0000
) (
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  input wire logic i_over,
  input wire logic i_hot,
  output logic o_miso,
  output logic o_alarm_pin,
  output logic o_crit_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // mode field positions in the config register are our own choice
  localparam int CMP_BIT = 4;
  localparam int SHDN_BIT = 0;
  logic [15:0] regs [8];
  logic [7:0] cmd = 8'h00;
  logic [15:0] sh = 16'h0000;
  logic alarm_q = 1'b1;
  int nbit = 0;
  int ones = 0;
  int w = 8;

  function automatic int width(input logic [2:0] a);
    return (a == 3'h2 || a == 3'h4 || a >= 3'h6) ? 16 : 8;
  endfunction

  task automatic defaults();
    regs = '{STAT_RST, CFG_RST, TEMP_RST, {8'h00, ID_VAL}, 16'h4980, 16'h0005, 16'h2000, 16'h0500};
  endtask

  initial begin
    defaults();
    o_miso = 1'b0;
    alarm_q = 1'b0; // interrupt mode, inactive after power-up
  end

  // samples only while selected, so a free-running clock is harmless
  always @(posedge i_sclk) if (!i_cs_n) begin
    ones = i_mosi ? ones + 1 : 0;
    if (nbit < 8) cmd = {cmd[6:0], i_mosi};
    else sh = {sh[14:0], i_mosi};
    nbit++;
    w = width(cmd[5:3]);
    if (nbit == 8 + w) begin
      if (!cmd[6] && cmd[5:3] inside {3'h1, 3'h4, 3'h5, 3'h6, 3'h7})
        regs[cmd[5:3]] = (w == 16) ? sh : {8'h00, sh[7:0]};
      if (!cmd[6] && cmd[5:3] == 3'h1 && !regs[1][CMP_BIT] && regs[1][SHDN_BIT]) alarm_q = 1'b0;
      if (cmd[6] && !regs[1][CMP_BIT]) alarm_q = 1'b0;
      nbit = 0;
    end
    if (ones >= 32) begin
      defaults();
      nbit = 0;
      ones = 0;
    end
  end

  // undriven output flips so a stale bit never looks valid
  always @(negedge i_sclk) begin
    if (!i_cs_n && nbit >= 8 && cmd[6]) o_miso <= regs[cmd[5:3]][w - 1 - (nbit - 8)];
    else o_miso <= ~o_miso;
  end

  always @(posedge i_cs_n) begin
    nbit = 0;
    ones = 0;
    o_miso <= ~o_miso;
  end

  always @(posedge i_over) alarm_q = 1'b1;
  // comparator mode: only leaving the deadband clears, shutdown does not
  always @(negedge i_over) if (regs[1][CMP_BIT] === 1'b1) alarm_q = 1'b0;
  assign o_alarm_pin = alarm_q ? 1'b0 : 1'b1; // open drain with pull-up
  assign o_crit_pin = i_hot ? 1'b0 : 1'b1;
endmodule

/* File: tb/temp_spi_host_test.sv */
module temp_spi_host_test;
  import temp_spi_host_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GUARD = 50;
  localparam logic [7:0] ID_VAL = 8'h5a; // arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, rd;
  logic ack, sclk, cs_n, mosi, miso, alarm_pin, crit_pin;
  logic over = 1'b0, hot = 1'b0, three = 1'b0, pol = 1'b0;
  logic [15:0] exp_reg [8];
  int error_cnt = 0;
  int n_tests = 0;
  int seed = 32'had9e;

  always #2 clk = ~clk;

  temp_spi_host #(.SCLK_HALF(4), .GUARD_CYC(GUARD)) u_temp_spi_host (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_mosi(mosi), .i_miso(miso), .i_alarm(alarm_pin), .i_critical_alarm_out(crit_pin));

  sensor_dev_model #(.ID_VAL(ID_VAL)) u_sensor_dev_model (
    .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi), .i_over(over), .i_hot(hot),
    .o_miso(miso), .o_alarm_pin(alarm_pin), .o_crit_pin(crit_pin));

  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t pin=%h exp=%h", $time, got, exp);
    end
  endtask

  // entered just after a rising edge; holds until ack is seen or 100 cycles pass
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (ack !== 1'b1) error_cnt++;
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      wb(1'b0, STAT_OFS, 32'h0);
      n++;
    end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 400);
    if (rd[STAT_BUSY_BIT] !== 1'b0) error_cnt++;
  endtask

  task automatic spi(input logic rdf, input logic [2:0] a, input logic [15:0] d, output logic [15:0] q);
    logic wide;
    wide = (a == 3'h2 || a == 3'h4 || a >= 3'h6);
    wb(1'b1, TXD_OFS, {16'h0, d});
    wb(1'b1, CTRL_OFS, {23'h0, pol, three, 1'b0, wide, a, rdf, 1'b1});
    wait_idle();
    wb(1'b0, RXD_OFS, 32'h0);
    q = rd[15:0];
  endtask

  task automatic read_all();
    logic [15:0] q;
    for (int a = 0; a < 8; a++) begin
      spi(1'b1, 3'(a), 16'h0, q);
      chk({16'h0, q}, {16'h0, exp_reg[a]});
    end
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    logic [15:0] q, v;
    exp_reg = '{16'h0, 16'h0, 16'h0, {8'h0, ID_VAL}, 16'h4980, 16'h0005, 16'h2000, 16'h0500};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, STAT_OFS, 32'h0);
    chk(rd & 32'h7, 32'h0);
    wb(1'b1, 4'h2, 32'hffffffff);
    wb(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
    chk_bit(sclk, 1'b1);
    chk_bit(cs_n, 1'b1);
    $display("test reset values done");
    read_all();
    wb(1'b0, STAT_OFS, 32'h0);
    chk(rd & 32'h2, 32'h2);
    wb(1'b1, STAT_OFS, 32'h2);
    wb(1'b0, STAT_OFS, 32'h0);
    chk(rd & 32'h2, 32'h0);
    $display("test default read done");
    foreach (exp_reg[a]) begin
      if (a == 1 || a >= 4) begin
        v = 16'($random(seed));
        if (!(a == 4 || a >= 6)) v[15:8] = 8'h00;
        spi(1'b0, 3'(a), v, q);
        exp_reg[a] = v;
        chk({16'h0, u_sensor_dev_model.regs[a]}, {16'h0, v});
      end
    end
    read_all();
    $display("test write read done");
    wb(1'b1, CTRL_OFS, 32'h1be);
    wb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h1be);
    chk_bit(cs_n, 1'b0);
    wb(1'b1, CTRL_OFS, 32'h0);
    three = 1'b1;
    v = 16'($random(seed));
    spi(1'b0, 3'h6, v, q);
    exp_reg[6] = v;
    spi(1'b1, 3'h6, 16'h0, q);
    chk({16'h0, q}, {16'h0, v});
    chk_bit(cs_n, 1'b0);
    three = 1'b0;
    $display("test three wire done");
    wb(1'b1, CTRL_OFS, 32'h40);
    wb(1'b0, STAT_OFS, 32'h0);
    chk(rd & 32'h1, 32'h1);
    wait_idle();
    exp_reg = '{16'h0, 16'h0, 16'h0, {8'h0, ID_VAL}, 16'h4980, 16'h0005, 16'h2000, 16'h0500};
    read_all();
    $display("test interface reset done");
    over <= 1'b1;
    repeat (3) @(posedge clk);
    over <= 1'b0;
    repeat (8) @(posedge clk);
    wb(1'b0, STAT_OFS, 32'h0);
    chk(rd & 32'h8, 32'h8);
    spi(1'b1, 3'h3, 16'h0, q);
    repeat (8) @(posedge clk);
    wb(1'b0, STAT_OFS, 32'h0);
    chk(rd & 32'h8, 32'h0);
    spi(1'b1, 3'h5, 16'h0, q);
    wb(1'b0, STAT_OFS, 32'h0);
    chk(rd & 32'h8, 32'h0);
    hot <= 1'b1;
    repeat (8) @(posedge clk);
    wb(1'b0, STAT_OFS, 32'h0);
    chk(rd & 32'h10, 32'h10);
    hot <= 1'b0;
    pol = 1'b1;
    wb(1'b1, CTRL_OFS, 32'h100);
    repeat (8) @(posedge clk);
    wb(1'b0, STAT_OFS, 32'h0);
    chk(rd & 32'h18, 32'h18);
    pol = 1'b0;
    spi(1'b0, 3'h1, 16'h0010, q);
    over <= 1'b1;
    repeat (8) @(posedge clk);
    spi(1'b1, 3'h3, 16'h0, q);
    wb(1'b0, STAT_OFS, 32'h0);
    chk(rd & 32'h8, 32'h8);
    spi(1'b0, 3'h1, 16'h0011, q);
    wb(1'b0, STAT_OFS, 32'h0);
    chk(rd & 32'h8, 32'h8);
    over <= 1'b0;
    repeat (8) @(posedge clk);
    wb(1'b0, STAT_OFS, 32'h0);
    chk(rd & 32'h8, 32'h0);
    spi(1'b0, 3'h1, 16'h0000, q);
    over <= 1'b1;
    repeat (3) @(posedge clk);
    over <= 1'b0;
    repeat (8) @(posedge clk);
    wb(1'b0, STAT_OFS, 32'h0);
    chk(rd & 32'h8, 32'h8);
    spi(1'b0, 3'h1, 16'h0001, q);
    wb(1'b0, STAT_OFS, 32'h0);
    chk(rd & 32'h8, 32'h0);
    $display("test alarm done");
    tally_and_finish();
  end
endmodule
